// File: verilog/pao_pkg.sv
package pao_pkg;

   // Port width and pin positions
   localparam int unsigned PAO_PORT_W   = 8;
   localparam int unsigned PAO_BIT_REF  = 7;
   localparam int unsigned PAO_BIT_SS   = 6;
   localparam int unsigned PAO_BIT_SCK  = 5;
   localparam int unsigned PAO_BIT_MOSI = 4;
   localparam int unsigned PAO_BIT_IRQ1 = 3;
   localparam int unsigned PAO_BIT_CAP  = 4;
   localparam int unsigned PAO_BIT_MISO = 2;
   localparam int unsigned PAO_BIT_TX   = 1;
   localparam int unsigned PAO_BIT_RX   = 0;

   // Converter reference selection codes
   localparam logic [1:0] PAO_REF_SUPPLY   = 2'h0;
   localparam logic [1:0] PAO_REF_EXTERNAL = 2'h1;
   localparam logic [1:0] PAO_REF_INT_1V1  = 2'h2;
   localparam logic [1:0] PAO_REF_INT_2V56 = 2'h3;

   // Override set for one pin
   typedef struct packed {
      logic puoe;
      logic puov;
      logic ddoe;
      logic ddov;
      logic pvoe;
      logic pvov;
   } pao_ovr_t;

   // Pad control for one pin
   typedef struct packed {
      logic pullup_en;
      logic drive_en;
      logic drive_val;
   } pao_pad_t;

   localparam pao_ovr_t PAO_OVR_NONE = '0;

   // Pin forced to input, pull-up still steered by its output bit
   function automatic pao_ovr_t pao_forced_in(input logic out_bit, input logic pu_off);
      pao_ovr_t o;
      o      = PAO_OVR_NONE;
      o.puoe = 1'h1;
      o.puov = out_bit & ~pu_off;
      o.ddoe = 1'h1;
      o.ddov = 1'h0;
      return o;
   endfunction

   // Pin fully isolated for analog use
   function automatic pao_ovr_t pao_isolated();
      pao_ovr_t o;
      o      = PAO_OVR_NONE;
      o.puoe = 1'h1;
      o.ddoe = 1'h1;
      return o;
   endfunction

endpackage

// File: verilog/pao_pin_cell.sv
`timescale 1ns/100ps
module pao_pin_cell
   import pao_pkg::*;
(
   input  wire pao_ovr_t ovr,
   input  wire logic     pin_direction_bit,
   input  wire logic     pin_output_bit,
   input  wire logic     pullup_disable,
   output pao_pad_t      pad
);

   logic drive_en;

   // Output driver enable: override or direction bit
   assign drive_en = ovr.ddoe ? ovr.ddov : pin_direction_bit;

   // Pad controls from the generic override scheme
   always_comb begin
      pad.drive_en  = drive_en;
      pad.drive_val = ovr.pvoe ? ovr.pvov : pin_output_bit;
      if (ovr.puoe) begin
         pad.pullup_en = ovr.puov;
      end else begin
         pad.pullup_en = ~pin_direction_bit & pin_output_bit & ~pullup_disable;
      end
   end

endmodule // pao_pin_cell

// File: verilog/pao_port_a.sv
`timescale 1ns/100ps
module pao_port_a
   import pao_pkg::*;
#(
   parameter int unsigned CAPTURE_BIT = PAO_BIT_CAP,
   parameter int unsigned IRQ1_BIT    = PAO_BIT_IRQ1
)(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [PAO_PORT_W-1:0] pin_direction_bit,
   input  wire logic [PAO_PORT_W-1:0] pin_output_bit,
   input  wire logic [PAO_PORT_W-1:0] pad_in,
   input  wire logic                  global_pullup_disable,
   input  wire logic                  port_a_pullup_disable,
   input  wire logic                  ref_output_enable,
   input  wire logic [1:0]            ref_select,
   input  wire logic                  ref_bypass_use,
   input  wire logic                  spi_enable,
   input  wire logic                  spi_master,
   input  wire logic                  sck_output,
   input  wire logic                  mosi_output,
   input  wire logic                  miso_output,
   input  wire logic                  three_wire_mode,
   input  wire logic                  three_wire_data_out,
   input  wire logic                  timer0_compare_en,
   input  wire logic                  timer0_compare_out_a,
   input  wire logic                  lin_tx_enable,
   input  wire logic                  lin_tx,
   input  wire logic                  lin_rx_enable,
   output logic [PAO_PORT_W-1:0]      pad_pullup_en,
   output logic [PAO_PORT_W-1:0]      pad_drive_en,
   output logic [PAO_PORT_W-1:0]      pad_drive_val,
   output logic                       internal_ref_out,
   output logic                       external_ref_in,
   output logic                       spi_slave_active,
   output logic                       three_wire_clock_in,
   output logic                       three_wire_data_in,
   output logic                       timer1_capture_in,
   output logic                       timer1_clock_in,
   output logic                       ext_irq1_in,
   output logic                       lin_receive_pin,
   output logic [PAO_PORT_W-1:0]      pin_change_src
);

   logic                  pullup_off;
   logic                  spi_slave;
   logic                  spi_mstr;
   logic                  ref_internal;
   logic                  bit7_isolate;
   pao_ovr_t              ovr [PAO_PORT_W];
   pao_pad_t              pad [PAO_PORT_W];

   // Pull-up disable merge; one bit covers the whole port
   assign pullup_off = global_pullup_disable | port_a_pullup_disable;

   // Serial peripheral role decode
   assign spi_slave = spi_enable & ~spi_master;
   assign spi_mstr  = spi_enable & spi_master;

   // Reference routing to bit 7
   assign ref_internal = (ref_select == PAO_REF_INT_1V1) |
                         (ref_select == PAO_REF_INT_2V56);
   assign internal_ref_out = ref_output_enable & ref_internal;
   assign external_ref_in  = (ref_select == PAO_REF_EXTERNAL);
   assign bit7_isolate     = internal_ref_out | external_ref_in | ref_bypass_use;

   // Bit 7: analog reference pin
   always_comb begin
      ovr[PAO_BIT_REF] = PAO_OVR_NONE;
      if (bit7_isolate) begin
         ovr[PAO_BIT_REF] = pao_isolated();
      end
   end

   // Bit 6: slave select
   always_comb begin
      ovr[PAO_BIT_SS] = PAO_OVR_NONE;
      if (spi_slave) begin
         ovr[PAO_BIT_SS] = pao_forced_in(pin_output_bit[PAO_BIT_SS], pullup_off);
      end
   end

   // Bit 5: serial clock
   always_comb begin
      ovr[PAO_BIT_SCK] = PAO_OVR_NONE;
      if (spi_slave) begin
         ovr[PAO_BIT_SCK] = pao_forced_in(pin_output_bit[PAO_BIT_SCK], pullup_off);
      end else if (spi_mstr) begin
         ovr[PAO_BIT_SCK].pvoe = 1'h1;
         ovr[PAO_BIT_SCK].pvov = sck_output;
      end
   end

   // Bit 4: master out, slave in; three-wire data in is not overridden
   always_comb begin
      ovr[PAO_BIT_MOSI] = PAO_OVR_NONE;
      if (spi_slave) begin
         ovr[PAO_BIT_MOSI] = pao_forced_in(pin_output_bit[PAO_BIT_MOSI], pullup_off);
      end else if (spi_mstr) begin
         ovr[PAO_BIT_MOSI].pvoe = 1'h1;
         ovr[PAO_BIT_MOSI].pvov = mosi_output;
      end
   end

   // Bit 3: plain port pin
   assign ovr[PAO_BIT_IRQ1] = PAO_OVR_NONE;

   // Bit 2: master in, slave out; three-wire out; timer compare
   always_comb begin
      ovr[PAO_BIT_MISO] = PAO_OVR_NONE;
      if (spi_mstr) begin
         ovr[PAO_BIT_MISO] = pao_forced_in(pin_output_bit[PAO_BIT_MISO], pullup_off);
      end else if (spi_slave) begin
         ovr[PAO_BIT_MISO].pvoe = 1'h1;
         ovr[PAO_BIT_MISO].pvov = miso_output;
      end else if (three_wire_mode) begin
         // Value only; driver and pull-up stay with direction and output bits
         ovr[PAO_BIT_MISO].pvoe = 1'h1;
         ovr[PAO_BIT_MISO].pvov = three_wire_data_out;
      end else if (timer0_compare_en) begin
         ovr[PAO_BIT_MISO].pvoe = 1'h1;
         ovr[PAO_BIT_MISO].pvov = timer0_compare_out_a;
      end
   end

   // Bit 1: UART/LIN transmit
   always_comb begin
      ovr[PAO_BIT_TX] = PAO_OVR_NONE;
      if (lin_tx_enable) begin
         ovr[PAO_BIT_TX].puoe = 1'h1;
         ovr[PAO_BIT_TX].puov = 1'h0;
         ovr[PAO_BIT_TX].ddoe = 1'h1;
         ovr[PAO_BIT_TX].ddov = 1'h1;
         ovr[PAO_BIT_TX].pvoe = 1'h1;
         ovr[PAO_BIT_TX].pvov = lin_tx;
      end
   end

   // Bit 0: UART/LIN receive
   always_comb begin
      ovr[PAO_BIT_RX] = PAO_OVR_NONE;
      if (lin_rx_enable) begin
         ovr[PAO_BIT_RX] = pao_forced_in(pin_output_bit[PAO_BIT_RX], pullup_off);
      end
   end

   // One generic cell per pin, purely combinational
   for (genvar i = 0; i < PAO_PORT_W; i++) begin : g_pin
      pao_pin_cell u_cell (
         .ovr               (ovr[i]),
         .pin_direction_bit (pin_direction_bit[i]),
         .pin_output_bit    (pin_output_bit[i]),
         .pullup_disable    (pullup_off),
         .pad               (pad[i])
      );
      assign pad_pullup_en[i] = pad[i].pullup_en;
      assign pad_drive_en[i]  = pad[i].drive_en;
      assign pad_drive_val[i] = pad[i].drive_val;
   end

   // Pad inputs fanned out to the peripherals
   assign pin_change_src      = pad_in;
   assign timer1_capture_in   = pad_in[CAPTURE_BIT];
   assign ext_irq1_in         = pad_in[IRQ1_BIT];
   assign timer1_clock_in     = pad_in[PAO_BIT_SCK];
   assign three_wire_clock_in = pad_in[PAO_BIT_SCK];
   assign three_wire_data_in  = pad_in[PAO_BIT_MOSI];
   assign lin_receive_pin     = pad_in[PAO_BIT_RX];

   // Slave select is low active from the external master
   assign spi_slave_active = spi_slave & ~pad_in[PAO_BIT_SS];

   // Checks on the pad controls

   property p_pud_kills_pullups;
      @(posedge clk) disable iff (!rst_n)
      (port_a_pullup_disable | global_pullup_disable) |->
         pad_pullup_en == '0;
   endproperty
   a_pud_kills_pullups: assert property (p_pud_kills_pullups)
      else $error("pull-up active while disabled");

   property p_ref_route;
      @(posedge clk) disable iff (!rst_n)
      internal_ref_out == (ref_output_enable &&
                           (ref_select == PAO_REF_INT_1V1 || ref_select == PAO_REF_INT_2V56));
   endproperty
   a_ref_route: assert property (p_ref_route)
      else $error("reference routing wrong");

   property p_ref_isolates;
      @(posedge clk) disable iff (!rst_n)
      (internal_ref_out || external_ref_in || ref_bypass_use) |->
         !pad_pullup_en[PAO_BIT_REF] && !pad_drive_en[PAO_BIT_REF];
   endproperty
   a_ref_isolates: assert property (p_ref_isolates)
      else $error("bit 7 not isolated");

   property p_slave_inputs;
      @(posedge clk) disable iff (!rst_n)
      (spi_enable && !spi_master) |->
         !pad_drive_en[PAO_BIT_SS] && !pad_drive_en[PAO_BIT_SCK] && !pad_drive_en[PAO_BIT_MOSI];
   endproperty
   a_slave_inputs: assert property (p_slave_inputs)
      else $error("slave pin driven");

   property p_master_dirs;
      @(posedge clk) disable iff (!rst_n)
      (spi_enable && spi_master) |->
         pad_drive_en[6:4] == pin_direction_bit[6:4] && !pad_drive_en[PAO_BIT_MISO];
   endproperty
   a_master_dirs: assert property (p_master_dirs)
      else $error("master direction wrong");

   property p_forced_pullup;
      @(posedge clk) disable iff (!rst_n)
      (spi_enable && spi_master) |->
         pad_pullup_en[PAO_BIT_MISO] == (pin_output_bit[PAO_BIT_MISO] && !pullup_off);
   endproperty
   a_forced_pullup: assert property (p_forced_pullup)
      else $error("forced input pull-up wrong");

   property p_slave_active;
      @(posedge clk) disable iff (!rst_n)
      spi_slave_active == (spi_enable && !spi_master && !pad_in[PAO_BIT_SS]);
   endproperty
   a_slave_active: assert property (p_slave_active)
      else $error("slave activity wrong");

   property p_three_wire_out;
      @(posedge clk) disable iff (!rst_n)
      (three_wire_mode && !spi_enable) |->
         pad_drive_en[PAO_BIT_MISO] == pin_direction_bit[PAO_BIT_MISO] &&
         (!pin_direction_bit[PAO_BIT_MISO] ||
          pad_drive_val[PAO_BIT_MISO] == three_wire_data_out);
   endproperty
   a_three_wire_out: assert property (p_three_wire_out)
      else $error("three-wire output wrong");

   property p_three_wire_pullup;
      @(posedge clk) disable iff (!rst_n)
      (three_wire_mode && !spi_enable && !pin_direction_bit[PAO_BIT_MISO]) |->
         pad_pullup_en[PAO_BIT_MISO] == (pin_output_bit[PAO_BIT_MISO] && !pullup_off);
   endproperty
   a_three_wire_pullup: assert property (p_three_wire_pullup)
      else $error("three-wire pull-up wrong");

   property p_capture_irq;
      @(posedge clk) disable iff (!rst_n)
      timer1_capture_in == pad_in[CAPTURE_BIT] && ext_irq1_in == pad_in[IRQ1_BIT];
   endproperty
   a_capture_irq: assert property (p_capture_irq)
      else $error("capture or interrupt input wrong");

   property p_default_pullup;
      @(posedge clk) disable iff (!rst_n)
      pad_pullup_en[PAO_BIT_IRQ1] ==
         (!pin_direction_bit[PAO_BIT_IRQ1] && pin_output_bit[PAO_BIT_IRQ1] && !pullup_off);
   endproperty
   a_default_pullup: assert property (p_default_pullup)
      else $error("default pull-up wrong");

   property p_tx_forced;
      @(posedge clk) disable iff (!rst_n)
      lin_tx_enable |->
         pad_drive_en[PAO_BIT_TX] && pad_drive_val[PAO_BIT_TX] == lin_tx &&
         !pad_pullup_en[PAO_BIT_TX];
   endproperty
   a_tx_forced: assert property (p_tx_forced)
      else $error("transmit pin not driven");

   property p_no_latency;
      @(posedge clk) disable iff (!rst_n)
      $changed(pin_direction_bit) && !spi_enable && !lin_tx_enable && !lin_rx_enable &&
         !ref_output_enable && !ref_bypass_use && ref_select == PAO_REF_SUPPLY |->
         pad_drive_en == pin_direction_bit;
   endproperty
   a_no_latency: assert property (p_no_latency)
      else $error("pad control lags configuration");

   // Checks on the remaining forced inputs and shared pins

   property p_rx_forced;
      @(posedge clk) disable iff (!rst_n)
      lin_rx_enable |->
         !pad_drive_en[PAO_BIT_RX] &&
         pad_pullup_en[PAO_BIT_RX] == (pin_output_bit[PAO_BIT_RX] && !pullup_off);
   endproperty
   a_rx_forced: assert property (p_rx_forced)
      else $error("receive pin not a plain input");

   property p_slave_pullups;
      @(posedge clk) disable iff (!rst_n)
      (spi_enable && !spi_master) |->
         pad_pullup_en[6:4] == (pin_output_bit[6:4] & {3{!pullup_off}});
   endproperty
   a_slave_pullups: assert property (p_slave_pullups)
      else $error("slave input pull-up wrong");

   property p_slave_miso;
      @(posedge clk) disable iff (!rst_n)
      (spi_enable && !spi_master) |->
         pad_drive_en[PAO_BIT_MISO] == pin_direction_bit[PAO_BIT_MISO] &&
         (!pin_direction_bit[PAO_BIT_MISO] || pad_drive_val[PAO_BIT_MISO] == miso_output);
   endproperty
   a_slave_miso: assert property (p_slave_miso)
      else $error("slave data out wrong");

   property p_compare_out;
      @(posedge clk) disable iff (!rst_n)
      (timer0_compare_en && !spi_enable && !three_wire_mode) |->
         pad_drive_en[PAO_BIT_MISO] == pin_direction_bit[PAO_BIT_MISO] &&
         (!pin_direction_bit[PAO_BIT_MISO] ||
          pad_drive_val[PAO_BIT_MISO] == timer0_compare_out_a);
   endproperty
   a_compare_out: assert property (p_compare_out)
      else $error("compare output wrong");

   property p_ext_ref;
      @(posedge clk) disable iff (!rst_n)
      external_ref_in == (ref_select == PAO_REF_EXTERNAL);
   endproperty
   a_ext_ref: assert property (p_ext_ref)
      else $error("external reference flag wrong");

   property p_master_values;
      @(posedge clk) disable iff (!rst_n)
      (spi_enable && spi_master) |->
         pad_drive_val[PAO_BIT_SCK] == sck_output &&
         pad_drive_val[PAO_BIT_MOSI] == mosi_output;
   endproperty
   a_master_values: assert property (p_master_values)
      else $error("master clock or data value wrong");

endmodule // pao_port_a

// File: verif/pao_pad_model.sv
`timescale 1ns/100ps
module pao_pad_model
   import pao_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic [PAO_PORT_W-1:0] pad_pullup_en,
   input  wire logic [PAO_PORT_W-1:0] pad_drive_en,
   input  wire logic [PAO_PORT_W-1:0] pad_drive_val,
   input  wire logic [PAO_PORT_W-1:0] ext_drive_en,
   input  wire logic [PAO_PORT_W-1:0] ext_drive_val,
   output logic [PAO_PORT_W-1:0]      pad_in
);
   logic [PAO_PORT_W-1:0] float_q = 8'h5A;

   // Loose pads wander every cycle so a stale level never passes
   always @(posedge clk) begin
      float_q <= ~pad_in;
   end

   // Pad level: chip driver, then outside driver, then pull-up
   always_comb begin
      for (int i = 0; i < PAO_PORT_W; i++) begin
         if (pad_drive_en[i]) begin
            pad_in[i] = pad_drive_val[i];
         end else if (ext_drive_en[i]) begin
            pad_in[i] = ext_drive_val[i];
         end else if (pad_pullup_en[i]) begin
            pad_in[i] = 1'b1;
         end else begin
            pad_in[i] = float_q[i];
         end
      end
   end
endmodule // pao_pad_model

// File: verif/test_port_a_alternate_function_override.sv
`timescale 1ns/100ps
module test_port_a_alternate_function_override
   import pao_pkg::*;
();
   localparam int unsigned CB = PAO_BIT_CAP;
   localparam int unsigned IB = PAO_BIT_IRQ1;
   logic                  clk, rst_n, gpud, apud, ref_oe, ref_byp, spi_en, spi_ms;
   logic                  sck_o, mosi_o, miso_o, tw_mode, tw_do, t0_en, t0_oc;
   logic                  lin_txe, lin_tx, lin_rxe, iref, eref, ssa, twc, twd, cap, t1c, irq1, rxp;
   logic [1:0]            ref_sel;
   logic [PAO_PORT_W-1:0] dir, outb, ext_en, ext_val, pu, de, dv, pad_in, pcs;
   int                    err_count, comparisons;

   pao_port_a #(.CAPTURE_BIT(CB), .IRQ1_BIT(IB)) pao_port_a_inst (
      .clk(clk), .rst_n(rst_n), .pin_direction_bit(dir), .pin_output_bit(outb),
      .pad_in(pad_in), .global_pullup_disable(gpud), .port_a_pullup_disable(apud),
      .ref_output_enable(ref_oe), .ref_select(ref_sel), .ref_bypass_use(ref_byp),
      .spi_enable(spi_en), .spi_master(spi_ms), .sck_output(sck_o), .mosi_output(mosi_o),
      .miso_output(miso_o), .three_wire_mode(tw_mode), .three_wire_data_out(tw_do),
      .timer0_compare_en(t0_en), .timer0_compare_out_a(t0_oc), .lin_tx_enable(lin_txe),
      .lin_tx(lin_tx), .lin_rx_enable(lin_rxe), .pad_pullup_en(pu), .pad_drive_en(de),
      .pad_drive_val(dv), .internal_ref_out(iref), .external_ref_in(eref),
      .spi_slave_active(ssa), .three_wire_clock_in(twc), .three_wire_data_in(twd),
      .timer1_capture_in(cap), .timer1_clock_in(t1c), .ext_irq1_in(irq1),
      .lin_receive_pin(rxp), .pin_change_src(pcs));

   pao_pad_model pao_pad_model_inst (
      .clk(clk), .pad_pullup_en(pu), .pad_drive_en(de), .pad_drive_val(dv),
      .ext_drive_en(ext_en), .ext_drive_val(ext_val), .pad_in(pad_in));

   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk1(input string nm, input logic exp, input logic got);
      chk8(nm, {7'h0, exp}, {7'h0, got});
   endtask

   // All inputs back to a quiet plain-port setup
   task automatic defaults();
      {gpud, apud, ref_oe, ref_byp, spi_en, spi_ms, sck_o, mosi_o, miso_o} = '0;
      {tw_mode, tw_do, t0_en, t0_oc, lin_txe, lin_tx, lin_rxe} = '0;
      ref_sel = PAO_REF_SUPPLY;
      {dir, outb, ext_en, ext_val} = '0;
   endtask

   task automatic idle();
      @(negedge clk);
      defaults();
   endtask

   task automatic test_pullups();
      for (int k = 0; k < 4; k++) begin
         idle();
         dir = 8'h0F;
         outb = 8'h3C;
         {gpud, apud} = k[1:0];
         #1;
         chk8("pullup", ~dir & outb & {8{~(gpud | apud)}}, pu);
         chk8("drive_en", dir, de);
         chk8("drive_val", outb & dir, dv & de);
      end
   endtask

   task automatic test_ref();
      logic on, iso;
      for (int k = 0; k < 32; k++) begin
         idle();
         {dir[7], ref_byp, ref_oe, ref_sel} = k[4:0];
         outb = 8'h80;
         on = ref_oe & (ref_sel == PAO_REF_INT_1V1 || ref_sel == PAO_REF_INT_2V56);
         iso = on | (ref_sel == PAO_REF_EXTERNAL) | ref_byp;
         #1;
         chk1("internal_ref_out", on, iref);
         chk1("external_ref_in", ref_sel == PAO_REF_EXTERNAL, eref);
         chk1("bit7 drive_en", ~iso & dir[7], de[7]);
         chk1("bit7 pullup", ~iso & ~dir[7], pu[7]);
      end
   endtask

   task automatic test_spi_slave();
      idle();
      spi_en = 1'b1;
      dir = 8'hFF;
      outb = 8'h70;
      miso_o = 1'b1;
      ext_en = 8'h70;
      #1;
      chk8("drive_en", 8'h8F, de);
      chk8("pullup", 8'h70, pu);
      chk1("miso value", 1'b1, dv[2]);
      chk1("slave active", 1'b1, ssa);
      @(negedge clk);
      ext_val = 8'h40;
      apud = 1'b1;
      dir = 8'hFB;
      #1;
      chk1("slave idle", 1'b0, ssa);
      chk8("pullup", 8'h00, pu);
      chk1("miso drive", 1'b0, de[2]);
   endtask

   task automatic test_spi_master();
      for (int v = 0; v < 2; v++) begin
         idle();
         {spi_en, spi_ms} = 2'b11;
         dir = 8'hFF;
         outb = 8'h04;
         {sck_o, mosi_o} = {v[0], ~v[0]};
         #1;
         chk8("drive_en", 8'hFB, de);
         chk8("pullup", 8'h04, pu);
         chk8("clk data", {sck_o, mosi_o, 6'h0}, {dv[5:4], 6'h0});
         @(negedge clk);
         dir = 8'h00;
         #1;
         chk8("drive_en", 8'h00, de);
         chk1("slave active", 1'b0, ssa);
      end
   endtask

   task automatic test_three_wire();
      for (int v = 0; v < 2; v++) begin
         idle();
         tw_mode = 1'b1;
         dir = 8'h04;
         tw_do = v[0];
         #1;
         chk8("bit2 drive", {1'b1, tw_do, 6'h0}, {de[2], dv[2], 6'h0});
         @(negedge clk);
         dir = 8'h00;
         outb = {5'h0, v[0], 2'h0};
         #1;
         chk8("bit2 in", {2'b0, v[0], 5'h0}, {de[2], 1'b0, pu[2], 5'h0});
         @(negedge clk);
         {tw_mode, t0_en, t0_oc} = {2'b01, v[0]};
         dir = 8'h04;
         #1;
         chk8("compare out", {1'b1, t0_oc, 6'h0}, {de[2], dv[2], 6'h0});
      end
   endtask

   task automatic test_lin_inputs();
      logic [7:0] p;
      for (int v = 0; v < 2; v++) begin
         idle();
         {lin_txe, lin_rxe, lin_tx} = {2'b11, v[0]};
         outb = 8'h02;
         ext_en = 8'hFD;
         p = v[0] ? 8'hAD : 8'h52;
         ext_val = p;
         #1;
         chk8("tx pin", {2'b10, lin_tx, 5'h0}, {de[1], pu[1], dv[1], 5'h0});
         chk8("pin change", {p[7:2], lin_tx, p[0]}, pcs);
         chk8("inputs", {p[CB], p[IB], p[5], p[5], p[4], p[0], 2'b0},
              {cap, irq1, t1c, twc, twd, rxp, 2'b0});
      end
   endtask

   task automatic complete_run();
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Hang guard, far beyond the few dozen cycles the tests use
   initial begin
      #200000;
      err_count++;
      complete_run();
   end

   // Reset, then the scenarios
   initial begin
      err_count = 0;
      comparisons = 0;
      rst_n = 1'b0;
      defaults();
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      test_pullups();
      test_ref();
      test_spi_slave();
      test_spi_master();
      test_three_wire();
      test_lin_inputs();
      complete_run();
   end
endmodule // test_port_a_alternate_function_override
